/* logic/serial_rx_pkg.sv */
// constants shared by the serial audio input receiver and its helpers
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package serial_rx_pkg;

  // register map, reached over the plain register port
  localparam logic [11:0] SERIAL_INPUT_CONTROL_ADDR = 12'h81f;
  localparam logic [11:0] SERIAL_INPUT_STATUS_ADDR = 12'h820;
  localparam logic [7:0] SERIAL_INPUT_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'h1f;

  // control fields
  localparam int FORMAT_LSB = 0;
  localparam int FORMAT_MSB = 2;
  localparam int BIT_CLOCK_POLARITY_BIT = 3;
  localparam int WORD_CLOCK_POLARITY_BIT = 4;

  // status fields
  localparam int STATUS_EMPTY_BIT = 0;
  localparam int STATUS_FULL_BIT = 1;
  localparam int STATUS_OVERFLOW_BIT = 2;
  localparam int STATUS_RUNNING_BIT = 3;

  // format field codes
  localparam logic [2:0] FORMAT_I2S = 3'h0;
  localparam logic [2:0] FORMAT_LEFT_JUSTIFIED = 3'h1;
  localparam logic [2:0] FORMAT_TDM = 3'h2;
  localparam logic [2:0] FORMAT_RIGHT_JUSTIFIED_24 = 3'h3;

  // framing
  localparam int SAMPLE_BITS = 24;
  localparam int TDM_SLOT_BITS = 32;
  localparam int TDM_SLOTS = 8;
  localparam int CHANNEL_BITS = 3;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_STAGES = 2;

endpackage

`default_nettype wire

/* logic/pin_sync.sv */
// two-stage synchroniser for a group of asynchronous pins
// assumes the pins change slowly against clk_in (several clocks per level)
`default_nettype none
`timescale 1ns/100ps

module pin_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] pins_in,
  output logic [WIDTH-1:0] synced_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  // stage1 feeds stage2 only
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= pins_in;
      stage2 <= stage1;
    end
  end

  assign synced_out = stage2;

endmodule

`default_nettype wire

/* logic/sample_fifo.sv */
// flip-flop fifo between the receiver and the sample consumer
// assumes one clock domain; valid/ready handshake on both sides
`default_nettype none
`timescale 1ns/100ps

module sample_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic full_out,
  output logic empty_out
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid_in & in_ready_out;
  wire pop = out_valid_out & out_ready_in;
  wire wr_wrap = (wr_ptr == AW'(DEPTH - 1));
  wire rd_wrap = (rd_ptr == AW'(DEPTH - 1));

  assign full_out = (count == (AW+1)'(DEPTH));
  assign empty_out = (count == '0);
  assign in_ready_out = ~full_out;
  assign out_valid_out = ~empty_out;
  assign out_data_out = mem[rd_ptr];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_wrap ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_wrap ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* logic/serial_audio_rx.sv */
// serial audio input port: control register, frame decode, sample fifo
// assumes bit clock, word clock and data come from an external source,
// bit clock well below a quarter of sys_clk_in
//
// The address-and-strobe port was decided locally.
`default_nettype none
`timescale 1ns/100ps

// Function
// - polarity 0: word clock low carries left, high carries right.
// - polarity 1: channel assignment swapped, high left, low right.
// - tdm, polarity 0: frame starts at sample edge after falling word clock.
// - tdm, polarity 1: frame starts at sample edge after rising word clock.
// - tdm: pulse word clock accepted; its first edge starts the frame.
// - bit clock polarity 0: data changes on falling edge, else rising.
// - format field selects framing; polarity bits override, written together.
// - tdm slot msb comes one bit clock after slot start.
// - tdm channels 0-3 in first frame half, 4-7 in second.
// - format 000 i2s, 001 left, 010 tdm, 011 right justified 24-bit.
module serial_audio_rx #(
  parameter int SAMPLE_W = serial_rx_pkg::SAMPLE_BITS,
  parameter int FIFO_DEPTH = serial_rx_pkg::FIFO_DEPTH,
  parameter int LINES = 4
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic bit_clock_in,
  input wire logic word_clock_in,
  input wire logic [LINES-1:0] rx_serial_data_lines_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [7:0] reg_rdata_out,
  output logic [SAMPLE_W-1:0] sample_data_out,
  output logic [serial_rx_pkg::CHANNEL_BITS-1:0] sample_channel_out,
  output logic sample_valid_out,
  input wire logic sample_ready_in
);

  localparam int CW = serial_rx_pkg::CHANNEL_BITS;
  localparam int FW = SAMPLE_W + CW;
  localparam int PW = $clog2(serial_rx_pkg::TDM_SLOT_BITS * serial_rx_pkg::TDM_SLOTS);
  localparam int SW = $clog2(serial_rx_pkg::TDM_SLOT_BITS);

  typedef enum logic [1:0] {
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10
  } rx_state_e;

  // msb delay in bit clocks per format
  function automatic logic msb_delay(input logic [2:0] fmt);
    msb_delay = (fmt == serial_rx_pkg::FORMAT_I2S) || (fmt == serial_rx_pkg::FORMAT_TDM);
  endfunction

  // reset release
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // pin capture; only the first data line is used, which serves tdm too
  logic [2:0] pins;
  logic s_bclk;
  logic s_lr;
  logic s_data;
  pin_sync #(.WIDTH(3)) u_sync (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .pins_in({bit_clock_in, word_clock_in, rx_serial_data_lines_in[0]}),
    .synced_out(pins)
  );
  assign s_bclk = pins[2];
  assign s_lr = pins[1];
  assign s_data = pins[0];

  // control register
  logic [7:0] ctrl;
  logic overflow;
  wire [2:0] fmt = ctrl[serial_rx_pkg::FORMAT_MSB:serial_rx_pkg::FORMAT_LSB];
  wire bit_pol = ctrl[serial_rx_pkg::BIT_CLOCK_POLARITY_BIT];
  wire word_pol = ctrl[serial_rx_pkg::WORD_CLOCK_POLARITY_BIT];
  wire ctrl_hit = reg_addr_in == serial_rx_pkg::SERIAL_INPUT_CONTROL_ADDR;
  wire stat_hit = reg_addr_in == serial_rx_pkg::SERIAL_INPUT_STATUS_ADDR;
  wire ctrl_wr = reg_write_in & ctrl_hit;
  wire stat_wr = reg_write_in & stat_hit;

  // all five control bits land in one write, so format and polarities never disagree
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= serial_rx_pkg::SERIAL_INPUT_CONTROL_RESET;
    end else if (ctrl_wr) begin
      ctrl <= reg_wdata_in & serial_rx_pkg::CONTROL_WRITE_MASK;
    end
  end

  wire is_i2s = fmt == serial_rx_pkg::FORMAT_I2S;
  wire is_lj = fmt == serial_rx_pkg::FORMAT_LEFT_JUSTIFIED;
  wire is_tdm = fmt == serial_rx_pkg::FORMAT_TDM;
  wire is_rj = fmt == serial_rx_pkg::FORMAT_RIGHT_JUSTIFIED_24;
  wire is_slot_fmt = is_i2s | is_lj;
  wire delay = msb_delay(fmt);

  // edge detection on the synchronised bit clock
  logic bclk_prev;
  logic lr_prev;
  logic lr_seen;
  wire bclk_rise = s_bclk & ~bclk_prev;
  wire bclk_fall = ~s_bclk & bclk_prev;
  // data moves on falling edge when bit_pol is 0, so sample on the rising one
  wire sample_edge = bit_pol ? bclk_fall : bclk_rise;
  wire word_change = sample_edge & lr_seen & (s_lr != lr_prev);
  // a pulse word clock only starts frames on its leading edge
  wire tdm_start = word_change & (word_pol ? s_lr : ~s_lr);
  wire [CW-1:0] lr_channel = {{(CW-1){1'b0}}, s_lr ^ word_pol};

  // receive state
  rx_state_e state;
  rx_state_e next_state;
  logic [PW-1:0] cnt;
  logic [PW-1:0] next_cnt;
  logic [SAMPLE_W-1:0] shift;
  logic [SAMPLE_W-1:0] next_shift;
  logic [CW-1:0] chan;
  logic [CW-1:0] next_chan;
  logic emit;
  logic next_emit;
  logic [SAMPLE_W-1:0] emit_word;
  logic [SAMPLE_W-1:0] next_emit_word;
  logic [CW-1:0] emit_chan;
  logic [CW-1:0] next_emit_chan;

  wire frame_edge = is_tdm ? tdm_start : word_change;
  wire [PW-1:0] pos = frame_edge ? '0 : cnt;
  wire [PW-1:0] pos_inc = pos + 1'b1;
  wire cnt_full = &cnt;
  wire [SW-1:0] slot_pos = pos[SW-1:0];
  wire [CW-1:0] slot_num = pos[PW-1:SW];
  // stereo bit index, msb arrives after the configured delay
  wire [PW-1:0] st_idx = pos - PW'(delay);
  wire st_take = (pos >= PW'(delay)) && (st_idx < PW'(SAMPLE_W));
  wire st_last = st_take && (st_idx == PW'(SAMPLE_W - 1));
  // tdm slot bits sit at slot positions 1 .. SAMPLE_W
  wire td_take = (slot_pos != '0) && (slot_pos <= SW'(SAMPLE_W));
  wire td_last = slot_pos == SW'(SAMPLE_W);
  wire [SAMPLE_W-1:0] shifted = {shift[SAMPLE_W-2:0], s_data};

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shift = shift;
    next_chan = chan;
    next_emit = 1'b0;
    next_emit_word = emit_word;
    next_emit_chan = emit_chan;
    case (state)
      ST_WAIT: begin
        if (frame_edge && (is_slot_fmt || is_tdm || is_rj)) begin
          next_state = ST_RUN;
          next_cnt = pos_inc;
          next_chan = lr_channel;
          next_shift = shifted;
        end
      end
      ST_RUN: begin
        if (sample_edge) begin
          next_cnt = cnt_full && !frame_edge ? cnt : pos_inc;
          if (is_rj) begin
            // word ends where the word clock flips, keep the last 24 bits
            next_shift = shifted;
            if (word_change) begin
              next_emit = 1'b1;
              next_emit_word = shift;
              next_emit_chan = chan;
              next_chan = lr_channel;
            end
          end else if (is_tdm) begin
            if (td_take) begin
              next_shift = shifted;
            end
            if (td_last) begin
              next_emit = 1'b1;
              next_emit_word = shifted;
              next_emit_chan = slot_num;
            end
            if (cnt_full && !frame_edge) begin
              next_state = ST_WAIT;
            end
          end else begin
            if (word_change) begin
              next_chan = lr_channel;
            end
            if (st_take) begin
              next_shift = shifted;
            end
            if (st_last) begin
              next_emit = 1'b1;
              next_emit_word = shifted;
              next_emit_chan = word_change ? lr_channel : chan;
            end
          end
        end
      end
      default: begin
        next_state = ST_WAIT;
      end
    endcase
    // reserved formats and any control change restart framing
    if (ctrl_wr || !(is_slot_fmt || is_tdm || is_rj)) begin
      next_state = ST_WAIT;
      next_emit = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bclk_prev <= 1'b0;
      lr_prev <= 1'b0;
      lr_seen <= 1'b0;
    end else begin
      bclk_prev <= s_bclk;
      if (sample_edge) begin
        lr_prev <= s_lr;
        lr_seen <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_WAIT;
      cnt <= '0;
      shift <= '0;
      chan <= '0;
      emit <= 1'b0;
      emit_word <= '0;
      emit_chan <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shift <= next_shift;
      chan <= next_chan;
      emit <= next_emit;
      emit_word <= next_emit_word;
      emit_chan <= next_emit_chan;
    end
  end

  // sample fifo; the serial source cannot be stalled, so a full fifo drops
  // the sample and raises the overflow flag instead
  logic fifo_ready;
  logic fifo_full;
  logic fifo_empty;
  logic [FW-1:0] fifo_out;
  sample_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .in_data_in({emit_chan, emit_word}),
    .in_valid_in(emit),
    .in_ready_out(fifo_ready),
    .out_data_out(fifo_out),
    .out_valid_out(sample_valid_out),
    .out_ready_in(sample_ready_in),
    .full_out(fifo_full),
    .empty_out(fifo_empty)
  );
  assign sample_data_out = fifo_out[SAMPLE_W-1:0];
  assign sample_channel_out = fifo_out[FW-1:SAMPLE_W];

  // overflow is write-one-to-clear; a new drop in the same cycle wins
  wire overflow_set = emit & ~fifo_ready;
  wire overflow_clr = stat_wr & reg_wdata_in[serial_rx_pkg::STATUS_OVERFLOW_BIT];
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      overflow <= 1'b0;
    end else if (overflow_set) begin
      overflow <= 1'b1;
    end else if (overflow_clr) begin
      overflow <= 1'b0;
    end
  end

  // register read, data in the cycle after the strobe
  logic [7:0] status;
  always_comb begin
    status = 8'h00;
    status[serial_rx_pkg::STATUS_EMPTY_BIT] = fifo_empty;
    status[serial_rx_pkg::STATUS_FULL_BIT] = fifo_full;
    status[serial_rx_pkg::STATUS_OVERFLOW_BIT] = overflow;
    status[serial_rx_pkg::STATUS_RUNNING_BIT] = state == ST_RUN;
  end
  wire [7:0] read_mux = ctrl_hit ? ctrl : (stat_hit ? status : 8'h00);

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
      reg_rdata_out <= read_mux;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

endmodule

`default_nettype wire

/* tb/serial_audio_rx_properties.sv */
// checker for the serial audio receiver: register port and sample fifo
// assumes it is bound to serial_audio_rx and sees only its ports
`default_nettype none
`timescale 1ns/100ps

module serial_audio_rx_properties #(
  parameter int SAMPLE_W = 24
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [SAMPLE_W-1:0] sample_data_out,
  input wire logic [serial_rx_pkg::CHANNEL_BITS-1:0] sample_channel_out,
  input wire logic sample_valid_out,
  input wire logic sample_ready_in
);
  logic [4:0] ctrl;
  wire logic ctrl_hit = reg_addr_in == serial_rx_pkg::SERIAL_INPUT_CONTROL_ADDR;
  wire logic stat_hit = reg_addr_in == serial_rx_pkg::SERIAL_INPUT_STATUS_ADDR;
  wire logic reserved_fmt = ctrl[2];

  // shadow of the control bits, so readback is judged against what was written
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl <= 5'h00;
    end else if (reg_write_in && ctrl_hit) begin
      ctrl <= reg_wdata_in[4:0];
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence ctrl_read;
    reg_read_in && ctrl_hit;
  endsequence
  sequence stat_read;
    reg_read_in && stat_hit;
  endsequence

  a_ctrl_readback: assert property (ctrl_read |=> reg_rdata_out == {3'h0, ctrl})
    else $error("control readback differs from last write");
  a_ctrl_upper_zero: assert property (ctrl_read |=> reg_rdata_out[7:5] == 3'h0)
    else $error("control upper bits not zero");
  a_rdata_idle: assert property (!reg_read_in |=> reg_rdata_out == 8'h00)
    else $error("read data without a read strobe");
  a_unmapped_zero: assert property (
      reg_read_in && !ctrl_hit && !stat_hit |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_status_empty: assert property (
      stat_read |=> reg_rdata_out[0] == !$past(sample_valid_out))
    else $error("status empty bit disagrees with valid");
  a_valid_holds: assert property (
      sample_valid_out && !sample_ready_in |=>
      sample_valid_out && $stable(sample_data_out) && $stable(sample_channel_out))
    else $error("head sample changed while not accepted");
  a_pop_only: assert property ($fell(sample_valid_out) |-> $past(sample_ready_in))
    else $error("valid dropped without a pop");
  a_reserved_quiet: assert property (
      reserved_fmt && $past(reserved_fmt, 8) |-> !$rose(sample_valid_out))
    else $error("sample captured in a reserved format");
endmodule

bind serial_audio_rx serial_audio_rx_properties #(.SAMPLE_W(SAMPLE_W)) props_i (
  .sys_clk_in(sys_clk_in),
  .reset_n_in(reset_n_in),
  .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_write_in(reg_write_in),
  .reg_read_in(reg_read_in),
  .reg_rdata_out(reg_rdata_out),
  .sample_data_out(sample_data_out),
  .sample_channel_out(sample_channel_out),
  .sample_valid_out(sample_valid_out),
  .sample_ready_in(sample_ready_in)
);
`default_nettype wire

/* tb/serial_audio_source.sv */
// behavioural serial audio source: bit clock, word clock and one data line
// assumes the caller staggers frames off the system clock edges
`default_nettype none
`timescale 1ns/100ps

module serial_audio_source (
  output logic bit_clock_out,
  output logic word_clock_out,
  output logic data_out
);
  initial begin
    bit_clock_out = 1'b0;
    word_clock_out = 1'b1;
    data_out = 1'b0;
  end

  // two lead bits at the idle level give the receiver a reference before the frame edge
  task automatic send_frame(input logic [2:0] fmt, input logic bpol, input logic wpol,
                            input logic [23:0] w [8]);
    int n;
    int off;
    int k;
    n = (fmt == serial_rx_pkg::FORMAT_TDM) ? 256 : 64;
    off = (fmt == serial_rx_pkg::FORMAT_LEFT_JUSTIFIED) ? 0 :
          (fmt == serial_rx_pkg::FORMAT_RIGHT_JUSTIFIED_24) ? 8 : 1;
    for (int i = -2; i < n + 2; i++) begin
      k = (i & 31) - off;
      bit_clock_out = bpol; // data changes on this edge
      if (n == 256) begin
        word_clock_out = (i == 0) ? wpol : !wpol; // one-bit pulse
      end else begin
        word_clock_out = (i < 0) ? !wpol : (i >= n) ? wpol : wpol ^ i[5];
      end
      if (i >= 0 && i < n && k >= 0 && k < 24) begin
        data_out = w[i / 32][23 - k]; // one line carries everything
      end else begin
        data_out = !data_out;
      end
      #160;
      bit_clock_out = !bpol;
      #160;
    end
    // bit clock stands still between frames; data no longer holds its last bit
    bit_clock_out = bpol;
    data_out = !data_out;
  endtask
endmodule
`default_nettype wire

/* tb/serial_audio_rx_tb.sv */
// testbench for serial_audio_rx: register port, all framings, fifo overflow
// assumes serial_audio_source as the far side and the bound checker
`default_nettype none
`timescale 1ns/100ps

module serial_audio_rx_tb;
  localparam logic [11:0] ctrl_addr = serial_rx_pkg::SERIAL_INPUT_CONTROL_ADDR;
  localparam logic [11:0] stat_addr = serial_rx_pkg::SERIAL_INPUT_STATUS_ADDR;
  logic sys_clk_in, reset_n_in, wr, rd, ready;
  logic [11:0] addr;
  logic [7:0] wdata;
  wire logic bclk, wclk, sdata, svalid;
  wire logic [7:0] rdata;
  wire logic [23:0] sdat;
  wire logic [2:0] sch;
  int miscompares, n_tests;
  logic [23:0] w [8];
  // {word pol, bit pol, format}; right-justified follows a frame that left the word
  // clock low, so its lead bits raise no word change and no partial word is emitted
  logic [4:0] cfg [7] = '{5'h00, 5'h13, 5'h10, 5'h19, 5'h02, 5'h12, 5'h0a};

  serial_audio_source serial_audio_source_i (
    .bit_clock_out(bclk), .word_clock_out(wclk), .data_out(sdata));
  serial_audio_rx serial_audio_rx_i (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .bit_clock_in(bclk),
    .word_clock_in(wclk), .rx_serial_data_lines_in({{3{~sdata}}, sdata}),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd),
    .reg_rdata_out(rdata), .sample_data_out(sdat), .sample_channel_out(sch),
    .sample_valid_out(svalid), .sample_ready_in(ready));

  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  task automatic test_done;
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk_in);
    wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [11:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge sys_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_in);
    rd <= 1'b0;
    #1 check("register", rdata & m, exp);
  endtask

  task automatic pop_expect(input logic [2:0] ch, input logic [23:0] d);
    int k;
    k = 0;
    while (svalid !== 1'b1) begin
      @(posedge sys_clk_in);
      #1 k++;
      if (k > 3000) begin
        miscompares++;
        test_done();
      end
    end
    check("sample channel", sch, ch);
    check("sample data", sdat, d);
    @(posedge sys_clk_in);
    ready <= 1'b1;
    @(posedge sys_clk_in);
    ready <= 1'b0;
    #1;
  endtask

  initial begin
    {reset_n_in, wr, rd, ready, addr, wdata} = '0;
    miscompares = 0;
    n_tests = 0;
    repeat (4) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    reg_read(ctrl_addr, 8'hff, 8'h00);
    reg_read(stat_addr, 8'h07, 8'h01);
    reg_write(ctrl_addr, 8'hff);
    reg_read(ctrl_addr, 8'hff, 8'h1f);
    reg_write(12'h000, 8'hff);
    reg_read(12'h000, 8'hff, 8'h00);
    reg_read(ctrl_addr, 8'hff, 8'h1f);
    for (int s = 0; s < 7; s++) begin
      for (int i = 0; i < 8; i++) w[i] = {1'b1, 3'(s), 4'(i), 16'hc35a ^ 16'(i * 16'h0f11)};
      // the write also drops any partial word left by the previous frame
      reg_write(ctrl_addr, {3'h0, cfg[s]});
      #13 serial_audio_source_i.send_frame(cfg[s][2:0], cfg[s][3], cfg[s][4], w);
      for (int i = 0; i < ((cfg[s][2:0] == serial_rx_pkg::FORMAT_TDM) ? 8 : 2); i++) begin
        pop_expect(3'(i), w[i]);
      end
      reg_read(stat_addr, 8'h01, 8'h01);
    end
    reg_write(ctrl_addr, 8'h04);
    #13 serial_audio_source_i.send_frame(3'h4, 1'b0, 1'b0, w);
    reg_read(stat_addr, 8'h09, 8'h01);
    // consumer stalls over two frames: fifo fills, then refuses
    reg_write(ctrl_addr, 8'h02);
    #13 serial_audio_source_i.send_frame(3'h2, 1'b0, 1'b0, w);
    serial_audio_source_i.send_frame(3'h2, 1'b0, 1'b0, w);
    reg_read(stat_addr, 8'h07, 8'h06);
    reg_write(stat_addr, 8'h04);
    reg_read(stat_addr, 8'h04, 8'h00);
    for (int i = 0; i < 8; i++) pop_expect(3'(i), w[i]);
    reg_read(stat_addr, 8'h0f, 8'h01);
    test_done();
  end
endmodule
`default_nettype wire
